// ### logic/dcs_regs.sv
// register slice: calibration accumulator, oscillator sync and receiver power down
//
// How it works
// - 32-bit calibration tuning word built from bytes 0x1E2..0x1E5, low byte lowest.
// - tuning word, mode bits and sync bits held per main converter, page selects.
// - accumulator advances only while the accumulator enable bit is 1.
// - dc input select steers final synth input: 0 datapath, 1 constant dc.
// - frequency tuning enable acts on first converter only.
// - sync starts on rising edge of start bit or sysref, per chosen trigger.
// - pending tuning words load first, phase sync follows after load completes.
// - read-only acknowledge, per converter, rises once that oscillator is loaded.
// - master power-down, reset 1, holds all eight lanes and bias down.
`timescale 1ns/1ns
`default_nettype none
module dcs_regs #(
    parameter int N = dcs_pkg::NUM_CONV,
    parameter logic [7:0] DC_VALUE = 8'h7F
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire dcs_pkg::dcs_req_s req,
    output logic [dcs_pkg::DATA_W-1:0] rdata,
    // trigger inputs
    input wire logic sysref,
    input wire logic trig_is_sysref,
    // datapath
    input wire logic [7:0] path_in [N],
    output logic [7:0] synth_in [N],
    output logic [31:0] cal_phase [N],
    output logic [N-1:0] tune_active,
    output logic [N-1:0] osc_load,
    output logic [N-1:0] osc_sync,
    // receiver power
    output logic [dcs_pkg::LANES-1:0] lane_pd,
    output logic bias_pd
);
    import dcs_pkg::*;

    // ********************************
    // page select and input synchronisers
    // ********************************
    logic [N-1:0] page;
    logic [2:0] sref_pipe;
    logic [1:0] tsel_pipe;
    logic mpd;
    logic [31:0] frequency_tuning_word [N];
    dcs_mode_s mode [N];
    logic [N-1:0] start_bit;
    logic [N-1:0] start_prev;
    logic [N-1:0] ack;
    logic [N-1:0] trig;
    logic sref_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page <= N'(RST_PAGE);
        end else if (req.wr && req.addr == ADDR_PAGE) begin
            page <= req.wdata[N-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sref_pipe <= 3'h0;
            tsel_pipe <= 2'h0;
        end else begin
            sref_pipe <= {sref_pipe[1:0], sysref};
            tsel_pipe <= {tsel_pipe[0], trig_is_sysref};
        end
    end

    assign sref_rise = sref_pipe[1] && !sref_pipe[2];

    // ********************************
    // per converter registers and datapath
    // ********************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : conv
            logic sel;
            assign sel = page[g] && req.wr;

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    frequency_tuning_word[g] <= {4{RST_BYTE}};
                end else if (sel && mode[g].acc_en) begin
                    if (req.addr == ADDR_FTW0) begin
                        frequency_tuning_word[g][7:0] <= req.wdata;
                    end
                    if (req.addr == ADDR_FTW1) begin
                        frequency_tuning_word[g][15:8] <= req.wdata;
                    end
                    if (req.addr == ADDR_FTW2) begin
                        frequency_tuning_word[g][23:16] <= req.wdata;
                    end
                    if (req.addr == ADDR_FTW3) begin
                        frequency_tuning_word[g][31:24] <= req.wdata;
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mode[g] <= '0;
                    start_bit[g] <= 1'b0;
                end else begin
                    if (sel && req.addr == ADDR_MODE) begin
                        mode[g].acc_en <= req.wdata[BIT_ACC_EN];
                        mode[g].dc_sel <= req.wdata[BIT_DC_SEL];
                        mode[g].tune_en <= req.wdata[BIT_TUNE_EN];
                    end
                    if (sel && req.addr == ADDR_SYNC) begin
                        start_bit[g] <= req.wdata[BIT_START];
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    start_prev[g] <= 1'b0;
                    trig[g] <= 1'b0;
                end else begin
                    start_prev[g] <= start_bit[g];
                    trig[g] <= tsel_pipe[1] ? sref_rise
                        : (start_bit[g] && !start_prev[g]);
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cal_phase[g] <= 32'h0;
                end else if (mode[g].acc_en) begin
                    cal_phase[g] <= cal_phase[g] + frequency_tuning_word[g];
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    synth_in[g] <= 8'h00;
                    tune_active[g] <= 1'b0;
                end else begin
                    synth_in[g] <= mode[g].dc_sel ? DC_VALUE : path_in[g];
                    tune_active[g] <= (g == 0) && mode[g].tune_en;
                end
            end

            dcs_sync_seq u_seq (
                .clk(clk),
                .rst_b(rst_b),
                .trigger(trig[g]),
                .load_pulse(osc_load[g]),
                .sync_pulse(osc_sync[g]),
                .ack(ack[g])
            );

            acc_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
                !mode[g].acc_en |=> $stable(cal_phase[g]))
                else $error("accumulator moved while off");
            dc_mux_a: assert property (@(posedge clk) disable iff (!rst_b)
                mode[g].dc_sel |=> synth_in[g] == DC_VALUE)
                else $error("dc not selected");
            ftw_locked_a: assert property (@(posedge clk) disable iff (!rst_b)
                !mode[g].acc_en |=> $stable(frequency_tuning_word[g]))
                else $error("tuning word written while disabled");
        end
    endgenerate

    // ********************************
    // receiver master power down
    // ********************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mpd <= RST_MPD[BIT_MPD];
        end else if (req.wr && req.addr == ADDR_MPD) begin
            mpd <= req.wdata[BIT_MPD];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_pd <= '1;
            bias_pd <= 1'b1;
        end else begin
            lane_pd <= {LANES{mpd}};
            bias_pd <= mpd;
        end
    end

    // ********************************
    // read back through lowest selected page
    // ********************************
    int rp;
    always_comb begin
        rp = 0;
        for (int i = N - 1; i >= 0; i--) begin
            if (page[i]) begin
                rp = i;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
            if (req.rd) begin
                case (req.addr)
                    ADDR_PAGE: rdata <= 8'(page);
                    ADDR_FTW0: rdata <= frequency_tuning_word[rp][7:0];
                    ADDR_FTW1: rdata <= frequency_tuning_word[rp][15:8];
                    ADDR_FTW2: rdata <= frequency_tuning_word[rp][23:16];
                    ADDR_FTW3: rdata <= frequency_tuning_word[rp][31:24];
                    ADDR_MODE: rdata <= {5'h00, mode[rp].acc_en, mode[rp].dc_sel,
                        mode[rp].tune_en};
                    ADDR_SYNC: rdata <= {6'h00, ack[rp], start_bit[rp]};
                    ADDR_MPD: rdata <= {7'h00, mpd};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    pd_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        mpd |=> lane_pd == 8'hFF && bias_pd) else $error("lanes not powered down");
    tune_dac1_a: assert property (@(posedge clk) disable iff (!rst_b)
        !tune_active[1]) else $error("tuning on second converter");
    rd_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rd |=> rdata == 8'h00) else $error("read data outside read slot");
    rd_mpd_a: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && req.addr == ADDR_MPD |=> rdata[7:1] == 7'h00)
        else $error("reserved bits nonzero");

    load_seen_c: cover property (@(posedge clk) disable iff (!rst_b) osc_load[0]);
    sync_seen_c: cover property (@(posedge clk) disable iff (!rst_b) osc_sync[1]);
    dc_seen_c: cover property (@(posedge clk) disable iff (!rst_b) mode[0].dc_sel);
    pwr_up_c: cover property (@(posedge clk) disable iff (!rst_b) !bias_pd);
endmodule
`default_nettype wire

// ### pkg/dcs_pkg.sv
// package for the calibration accumulator and oscillator sync register slice
package dcs_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_CONV = 2;
    localparam logic [11:0] ADDR_PAGE = 12'h008;
    localparam logic [11:0] ADDR_FTW0 = 12'h1E2;
    localparam logic [11:0] ADDR_FTW1 = 12'h1E3;
    localparam logic [11:0] ADDR_FTW2 = 12'h1E4;
    localparam logic [11:0] ADDR_FTW3 = 12'h1E5;
    localparam logic [11:0] ADDR_MODE = 12'h1E6;
    localparam logic [11:0] ADDR_SYNC = 12'h1E7;
    localparam logic [11:0] ADDR_MPD = 12'h200;
    localparam int BIT_ACC_EN = 2;
    localparam int BIT_DC_SEL = 1;
    localparam int BIT_TUNE_EN = 0;
    localparam int BIT_ACK = 1;
    localparam int BIT_START = 0;
    localparam int BIT_MPD = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_MPD = 8'h01;
    localparam logic [1:0] RST_PAGE = 2'h3;
    localparam int LANES = 8;
    localparam logic [3:0] LOAD_CYCLES = 4'h4;
    localparam logic [3:0] SYNC_CYCLES = 4'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dcs_req_s;

    typedef struct packed {
        logic acc_en;
        logic dc_sel;
        logic tune_en;
    } dcs_mode_s;

    typedef enum logic [1:0] {
        DCS_IDLE,
        DCS_LOAD,
        DCS_SYNC,
        DCS_DONE
    } dcs_sync_e;
endpackage

// ### logic/dcs_sync_seq.sv
// per converter oscillator sync sequencer: load tuning words, then phase sync
`timescale 1ns/1ns
`default_nettype none
module dcs_sync_seq (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // trigger and status
    input wire logic trigger,
    output logic load_pulse,
    output logic sync_pulse,
    output logic ack
);
    import dcs_pkg::*;

    dcs_sync_e state;
    logic [3:0] count;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= DCS_IDLE;
            count <= 4'h0;
            load_pulse <= 1'b0;
            sync_pulse <= 1'b0;
            ack <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            sync_pulse <= 1'b0;
            unique case (state)
                DCS_IDLE: begin
                    if (trigger) begin
                        state <= DCS_LOAD;
                        count <= LOAD_CYCLES;
                        load_pulse <= 1'b1;
                        ack <= 1'b0;
                    end
                end
                DCS_LOAD: begin
                    if (count == 4'h1) begin
                        state <= DCS_SYNC;
                        count <= SYNC_CYCLES;
                        sync_pulse <= 1'b1;
                        ack <= 1'b1;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                DCS_SYNC: begin
                    if (count == 4'h1) begin
                        state <= DCS_DONE;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                DCS_DONE: begin
                    if (trigger) begin
                        state <= DCS_LOAD;
                        count <= LOAD_CYCLES;
                        load_pulse <= 1'b1;
                        ack <= 1'b0;
                    end
                end
            endcase
        end
    end

    sync_after_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        load_pulse |-> ##4 sync_pulse) else $error("sync did not follow load");
    ack_with_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
        sync_pulse |-> ack) else $error("ack missing at sync");
    ack_drop_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        load_pulse |-> !ack) else $error("ack held during load");
endmodule
`default_nettype wire

// ### testbench/test_dds_cal_and_nco_sync_regs.sv
// self-checking testbench for the calibration and oscillator sync register slice
`timescale 1ns/1ns
`default_nettype none
module test_dds_cal_and_nco_sync_regs;
    import dcs_pkg::*;

    // ********************
    // signals
    // ********************
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dcs_row_s;

    logic clk;
    logic rst_b;
    dcs_req_s req;
    logic [7:0] rdata;
    logic sysref;
    logic trig_is_sysref;
    logic [7:0] path_in [2];
    logic [7:0] synth_in [2];
    logic [31:0] cal_phase [2];
    logic [1:0] tune_active;
    logic [1:0] osc_load;
    logic [1:0] osc_sync;
    logic [7:0] lane_pd;
    logic bias_pd;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    int hits;
    logic [31:0] p0;
    logic [31:0] p1;
    dcs_row_s rows [15] = '{
        '{1'b1, ADDR_FTW0, 8'hAA, 8'h00}, '{1'b0, ADDR_FTW1, 8'h00, 8'h00},
        '{1'b0, ADDR_FTW2, 8'h00, 8'h00}, '{1'b0, ADDR_FTW3, 8'h00, 8'h00},
        '{1'b0, ADDR_MODE, 8'h00, 8'h00}, '{1'b0, ADDR_SYNC, 8'h00, 8'h00},
        '{1'b0, ADDR_MPD, 8'h00, 8'h01}, '{1'b1, ADDR_MODE, 8'hFF, 8'h07},
        '{1'b1, ADDR_FTW0, 8'h11, 8'h11}, '{1'b1, ADDR_FTW1, 8'h22, 8'h22},
        '{1'b1, ADDR_FTW2, 8'h33, 8'h33}, '{1'b1, ADDR_FTW3, 8'h44, 8'h44},
        '{1'b1, ADDR_SYNC, 8'hFE, 8'h00}, '{1'b1, ADDR_MPD, 8'hFE, 8'h00},
        '{1'b1, 12'h1E9, 8'hFF, 8'h00}};

    dcs_regs uut (
        .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .sysref(sysref), .trig_is_sysref(trig_is_sysref),
        .path_in(path_in), .synth_in(synth_in), .cal_phase(cal_phase),
        .tune_active(tune_active), .osc_load(osc_load), .osc_sync(osc_sync),
        .lane_pd(lane_pd), .bias_pd(bias_pd)
    );

    always #25 clk = ~clk;

    // ********************
    // tasks
    // ********************
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        // read data stand only until the next rising edge, so look mid-cycle
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask

    // counts edges until a load (sel 0) or sync (sel 1) pulse shows
    task automatic wait_pulse(input bit sel, output int cnt);
        for (cnt = 1; cnt <= 20; cnt++) begin
            @(negedge clk);
            if (sel ? (osc_sync != 2'b00) : (osc_load != 2'b00)) begin
                break;
            end
        end
        if (cnt > 20) begin
            chk(32'h0, 32'h1);
            print_verdict();
        end
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        sysref = 1'b0;
        trig_is_sysref = 1'b0;
        path_in[0] = 8'h5A;
        path_in[1] = 8'hA5;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(lane_pd, 8'hFF);
        chk(bias_pd, 1'b1);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, rows[i].e);
        end
        chk(lane_pd, 8'h00);
        chk(bias_pd, 1'b0);
        wr(ADDR_MPD, 8'h01);
        @(posedge clk);
        chk(lane_pd, 8'hFF);
        p0 = cal_phase[0];
        p1 = cal_phase[1];
        @(posedge clk);
        chk(cal_phase[0] - p0, 32'h44332211);
        chk(cal_phase[1] - p1, 32'h44332211);
        chk(synth_in[0], 8'h7F);
        chk(synth_in[1], 8'h7F);
        chk(tune_active, 2'b01);
        // page to first converter only, stop its accumulator
        wr(ADDR_PAGE, 8'h01);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_FTW0, 8'h99);
        rd(ADDR_FTW0, 8'h11);
        wr(ADDR_PAGE, 8'h02);
        rd(ADDR_MODE, 8'h07);
        p0 = cal_phase[0];
        p1 = cal_phase[1];
        @(posedge clk);
        chk(cal_phase[0] - p0, 32'h0);
        chk(cal_phase[1] - p1, 32'h44332211);
        chk(synth_in[0], 8'h5A);
        chk(synth_in[1], 8'h7F);
        chk(tune_active, 2'b00);
        // start-bit trigger on both converters
        wr(ADDR_PAGE, 8'h03);
        wr(ADDR_SYNC, 8'h01);
        wait_pulse(1'b0, n);
        chk(osc_load, 2'b11);
        chk(osc_sync, 2'b00);
        wait_pulse(1'b1, n);
        chk(n, LOAD_CYCLES);
        @(posedge clk);
        rd(ADDR_SYNC, 8'h03);
        // sysref chosen: start bit edge must do nothing
        trig_is_sysref <= 1'b1;
        wr(ADDR_SYNC, 8'h00);
        wr(ADDR_SYNC, 8'h01);
        hits = 0;
        repeat (10) begin
            @(posedge clk);
            if (osc_load != 2'b00) begin
                hits++;
            end
        end
        chk(hits, 0);
        sysref <= 1'b1;
        wait_pulse(1'b0, n);
        chk(osc_load, 2'b11);
        wait_pulse(1'b1, n);
        chk(n, LOAD_CYCLES);
        @(posedge clk);
        sysref <= 1'b0;
        rd(ADDR_SYNC, 8'h03);
        // second reset in mid-run
        rst_b <= 1'b0;
        @(posedge clk);
        chk(lane_pd, 8'hFF);
        chk(bias_pd, 1'b1);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_FTW0, 8'h00);
        rd(ADDR_MPD, 8'h01);
        print_verdict();
    end
endmodule
`default_nettype wire
